// *** design/esg_pkg.sv ***
package esg_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_GLOBAL_SETTINGS  = 6'h00;
    localparam logic [5:0] IDX_STATUS           = 6'h0F;
    localparam logic [5:0] IDX_GEARING_FACTOR   = 6'h12;
    localparam logic [5:0] IDX_ACTUAL_POSITION  = 6'h21;
    localparam logic [5:0] IDX_START_VELOCITY   = 6'h25;
    localparam logic [5:0] IDX_START_ACCEL      = 6'h2A;
    localparam logic [5:0] IDX_TARGET_POSITION  = 6'h37;

    // ------------------------------------------------------------
    // field positions in global_settings, plus the start acceleration sign bit
    // ------------------------------------------------------------
    localparam int unsigned MODE_LSB  = 6;
    localparam int unsigned POL_BIT   = 8;
    localparam int unsigned STEER_BIT = 9;
    localparam int unsigned AUTO_BIT  = 26;
    localparam int unsigned ACC_SIGN_BIT = 31;

    // ------------------------------------------------------------
    // gearing format, reset values and phase counter limit
    // ------------------------------------------------------------
    localparam int unsigned GEAR_INT_BITS  = 8;
    localparam int unsigned GEAR_FRAC_BITS = 24;
    localparam logic [31:0] GEAR_RST       = 32'h0100_0000;
    localparam logic [31:0] WORD_RST       = 32'h0000_0000;
    localparam logic [15:0] PHASE_MAX      = 16'hFFFF;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ              = 125_000_000;
    localparam int unsigned INDIRECT_SPACING_CYC = 64;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF    = 2'b00,
        MODE_RISE   = 2'b01,
        MODE_FALL   = 2'b10,
        MODE_TOGGLE = 2'b11
    } esg_mode_t;

    typedef struct packed {
        logic      auto_handover;
        logic      target_steer;
        logic      dir_pol;
        esg_mode_t step_mode;
    } esg_cfg_t;

    typedef struct packed {
        logic [31:0] vel;
        logic [31:0] acc;
        logic [15:0] phase;
    } esg_seed_t;

endpackage : esg_pkg

// *** design/esg_accum.sv ***
`timescale 1ns/1ps
module esg_accum
    import esg_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // external step
    input  wire logic        ext_step,
    input  wire logic        fwd,
    input  wire logic [31:0] gear,
    // overflow result
    output logic             ovf_valid,
    output logic             ovf_neg,
    output logic [7:0]       ovf_cnt
);

    logic [23:0] rem_q;
    logic signed [33:0] delta;
    logic signed [33:0] sum;
    logic signed [9:0]  whole;
    logic [9:0]         whole_mag;

    always_comb begin
        // signed 8.24 factor, sign of motion from direction
        delta = fwd ? 34'(signed'(gear)) : -34'(signed'(gear));
        sum   = signed'({10'h000, rem_q}) + delta;
        whole = sum[33:24];
        whole_mag = whole[9] ? 10'(-whole) : whole;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rem_q <= 24'h000000;
        end else if (ext_step) begin
            rem_q <= sum[23:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ovf_valid <= 1'b0;
            ovf_neg   <= 1'b0;
            ovf_cnt   <= 8'h00;
        end else begin
            ovf_valid <= ext_step && (whole != 10'sh000);
            ovf_neg   <= whole[9];
            ovf_cnt   <= whole_mag[7:0];
        end
    end

endmodule : esg_accum

// *** design/esg_top.sv ***
`timescale 1ns/1ps
// Behaviour
// - Mode 01 counts step on rising input, mode 10 on falling input.
// - Any external step mode disables the internal step generator.
// - Mode 11 counts a step on every input change.
// - Low direction means negative; polarity bit set makes high negative.
// - Gearing factor is signed fixed point, 8 integer and 24 fraction bits.
// - Each step adds the factor; each overflow is one internal step, remainder kept.
// - Any factor magnitude from two to minus 24 up to 127 works.
// - Multiple overflows give back-to-back steps; table position jumps directly.
// - Negative factor inverts the derived direction.
// - Indirect mode leaves actual position alone, moves target per overflow.
// - Target change sign follows the overflow direction.
// - Indirect mode: nonzero step mode plus steering bit; ramp follows target.
// - Auto handover needs steering clear and handover bit set; start accel is not checked.
// - Writing mode 00 requests the handover; internal ramping starts then.
// - Ramp starts at start velocity, direction from preceding external steps.
// - Handover carries the time since the last internal step.
// - Ramp acceleration is plus or minus start magnitude by bit 31.
module esg_top
    import esg_pkg::*;
#(
    parameter int unsigned SINE_W = 10
)(
    // clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              SRST,
    // register port
    input  wire logic [7:0]        ADDR,
    input  wire logic [31:0]       WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic [31:0]            RDATA,
    // external step source
    input  wire logic              STEP_IN,
    input  wire logic              DIR_IN,
    // internal step output
    output logic                   STEP_OUT,
    output logic                   DIR_OUT,
    output logic [SINE_W-1:0]      SINE_POS,
    output logic                   INT_GEN_EN,
    // internal ramp hand-off
    output logic                   RAMP_EN,
    output logic [31:0]            TARGET_POS,
    output logic                   HANDOVER,
    output esg_seed_t              RAMP_SEED
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_DIRECT, ST_INDIRECT, ST_RAMP} esg_state_t;

    esg_state_t         state_q;
    esg_state_t         state_d;
    esg_cfg_t           cfg_q;
    logic [31:0]        gear_q;
    logic [31:0]        start_velocity_q;
    logic [31:0]        start_acceleration_q;
    logic [31:0]        target_q;
    logic [31:0]        actual_q;
    logic signed [15:0] pend_q;
    logic [15:0]        phase_q;
    logic               step_prev_q;
    logic               ext_q;
    logic               ext_d;
    logic               acc_v;
    logic               acc_neg;
    logic [7:0]         acc_cnt;
    logic signed [15:0] acc_signed;
    logic               handover_go;
    logic               wr_glob;

    function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    assign wr_glob    = WR && hit(ADDR, IDX_GLOBAL_SETTINGS);
    assign acc_signed = acc_neg ? -16'(acc_cnt) : 16'(acc_cnt);
    assign handover_go = (state_q == ST_DIRECT) && (cfg_q.step_mode == MODE_OFF)
                         && cfg_q.auto_handover;

    // ------------------------------------------------------------
    // step input edge detection
    // ------------------------------------------------------------
    always_comb begin
        unique case (cfg_q.step_mode)
            MODE_OFF:    ext_d = 1'b0;
            MODE_RISE:   ext_d = STEP_IN && !step_prev_q;
            MODE_FALL:   ext_d = !STEP_IN && step_prev_q;
            MODE_TOGGLE: ext_d = STEP_IN != step_prev_q;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            step_prev_q <= 1'b0;
            ext_q       <= 1'b0;
        end else begin
            step_prev_q <= STEP_IN;
            ext_q       <= ext_d;
        end
    end

    // ------------------------------------------------------------
    // gearing accumulator
    // ------------------------------------------------------------
    esg_accum u_accum (
        .clk       (CLK_SYS),
        .srst      (SRST),
        .ext_step  (ext_q),
        .fwd       (DIR_IN ^ cfg_q.dir_pol),
        .gear      (gear_q),
        .ovf_valid (acc_v),
        .ovf_neg   (acc_neg),
        .ovf_cnt   (acc_cnt)
    );

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE, ST_RAMP: begin
                if (cfg_q.step_mode != MODE_OFF) begin
                    state_d = cfg_q.target_steer ? ST_INDIRECT : ST_DIRECT;
                end
            end
            ST_DIRECT: begin
                if (cfg_q.step_mode == MODE_OFF) begin
                    state_d = cfg_q.auto_handover ? ST_RAMP : ST_IDLE;
                end else if (cfg_q.target_steer) begin
                    state_d = ST_INDIRECT;
                end
            end
            ST_INDIRECT: begin
                if (cfg_q.step_mode == MODE_OFF) begin
                    state_d = ST_IDLE;
                end else if (!cfg_q.target_steer) begin
                    state_d = ST_DIRECT;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state_q    <= ST_IDLE;
            RAMP_EN    <= 1'b0;
            INT_GEN_EN <= 1'b1;
        end else begin
            state_q    <= state_d;
            RAMP_EN    <= (state_d == ST_INDIRECT) || (state_d == ST_RAMP);
            INT_GEN_EN <= (cfg_q.step_mode == MODE_OFF);
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            cfg_q <= '{auto_handover: 1'b0, target_steer: 1'b0, dir_pol: 1'b0, step_mode: MODE_OFF};
        end else if (wr_glob) begin
            cfg_q.step_mode     <= esg_mode_t'(WDATA[MODE_LSB +: 2]);
            cfg_q.dir_pol       <= WDATA[POL_BIT];
            cfg_q.target_steer  <= WDATA[STEER_BIT];
            cfg_q.auto_handover <= WDATA[AUTO_BIT];
        end else if (handover_go) begin
            cfg_q.auto_handover <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            gear_q   <= GEAR_RST;
            start_velocity_q <= WORD_RST;
            start_acceleration_q <= WORD_RST;
        end else if (WR) begin
            if (hit(ADDR, IDX_GEARING_FACTOR)) begin
                gear_q <= WDATA;
            end
            if (hit(ADDR, IDX_START_VELOCITY)) begin
                start_velocity_q <= WDATA;
            end
            if (hit(ADDR, IDX_START_ACCEL)) begin
                start_acceleration_q <= WDATA;
            end
        end
    end

    // ------------------------------------------------------------
    // target position
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            target_q <= WORD_RST;
        end else if (acc_v && (state_q == ST_INDIRECT)) begin
            // one unit per overflow, whole burst added in one cycle, no spacing limit
            target_q <= target_q + 32'(acc_signed);
        end else if (WR && hit(ADDR, IDX_TARGET_POSITION)) begin
            target_q <= WDATA;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            TARGET_POS <= WORD_RST;
        end else begin
            TARGET_POS <= target_q;
        end
    end

    // ------------------------------------------------------------
    // direct step emission
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pend_q   <= 16'sh0000;
            STEP_OUT <= 1'b0;
            DIR_OUT  <= 1'b0;
            actual_q <= WORD_RST;
        end else begin
            if (STEP_OUT) begin
                STEP_OUT <= 1'b0;
                pend_q   <= pend_q + ((acc_v && state_q == ST_DIRECT) ? acc_signed : 16'sh0000);
            end else if (pend_q != 16'sh0000) begin
                STEP_OUT <= 1'b1;
                DIR_OUT  <= !pend_q[15];
                actual_q <= pend_q[15] ? actual_q - 32'h0000_0001 : actual_q + 32'h0000_0001;
                pend_q   <= pend_q + (pend_q[15] ? 16'sh0001 : -16'sh0001)
                            + ((acc_v && state_q == ST_DIRECT) ? acc_signed : 16'sh0000);
            end else begin
                pend_q <= (acc_v && state_q == ST_DIRECT) ? acc_signed : 16'sh0000;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            SINE_POS <= '0;
        end else if (acc_v && (state_q == ST_DIRECT)) begin
            SINE_POS <= SINE_POS + SINE_W'(acc_signed);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            phase_q <= 16'h0000;
        end else if (STEP_OUT) begin
            phase_q <= 16'h0000;
        end else if (phase_q != PHASE_MAX) begin
            phase_q <= phase_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // handover seed
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            HANDOVER  <= 1'b0;
            RAMP_SEED <= '0;
        end else begin
            HANDOVER <= handover_go;
            if (handover_go) begin
                RAMP_SEED.vel   <= DIR_OUT ? start_velocity_q : -start_velocity_q;
                RAMP_SEED.acc   <= start_acceleration_q[ACC_SIGN_BIT] ? -{1'b0, start_acceleration_q[30:0]}
                                                          : {1'b0, start_acceleration_q[30:0]};
                RAMP_SEED.phase <= phase_q;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST || !RD) begin
            RDATA <= WORD_RST;
        end else begin
            RDATA <= WORD_RST;
            if (hit(ADDR, IDX_GLOBAL_SETTINGS)) begin
                RDATA[MODE_LSB +: 2] <= cfg_q.step_mode;
                RDATA[POL_BIT]       <= cfg_q.dir_pol;
                RDATA[STEER_BIT]     <= cfg_q.target_steer;
                RDATA[AUTO_BIT]      <= cfg_q.auto_handover;
            end else if (hit(ADDR, IDX_STATUS)) begin
                RDATA[5:0] <= {state_q, pend_q != 16'sh0000, DIR_OUT, RAMP_EN, INT_GEN_EN};
            end else if (hit(ADDR, IDX_GEARING_FACTOR)) begin
                RDATA <= gear_q;
            end else if (hit(ADDR, IDX_ACTUAL_POSITION)) begin
                RDATA <= actual_q;
            end else if (hit(ADDR, IDX_START_VELOCITY)) begin
                RDATA <= start_velocity_q;
            end else if (hit(ADDR, IDX_START_ACCEL)) begin
                RDATA <= start_acceleration_q;
            end else if (hit(ADDR, IDX_TARGET_POSITION)) begin
                RDATA <= target_q;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    a_rise_step_seen: assert property (
        (cfg_q.step_mode == MODE_RISE && STEP_IN && !step_prev_q) |=> ext_q)
        else $error("rising step not counted");

    a_fall_step_seen: assert property (
        (cfg_q.step_mode == MODE_FALL && !STEP_IN && step_prev_q) |=> ext_q)
        else $error("falling step not counted");

    a_toggle_step_seen: assert property (
        (cfg_q.step_mode == MODE_TOGGLE) |=> (ext_q == ($past(STEP_IN) != $past(step_prev_q))))
        else $error("toggle step mismatch");

    a_int_gen_off: assert property (
        (cfg_q.step_mode != MODE_OFF) |=> !INT_GEN_EN)
        else $error("internal generator not disabled");

    a_indirect_actual_held: assert property (
        (state_q == ST_INDIRECT && pend_q == 16'sh0000 && !STEP_OUT) |=> $stable(actual_q) && pend_q == 16'sh0000)
        else $error("actual moved in indirect mode");

    a_target_one_step: assert property (
        (acc_v && state_q == ST_INDIRECT && acc_cnt == 8'h01)
        |=> target_q == $past(target_q) + ($past(acc_neg) ? 32'hFFFF_FFFF : 32'h0000_0001))
        else $error("target step wrong");

    a_burst_spacing: assert property (
        STEP_OUT |=> !STEP_OUT ##1 ($past(pend_q, 1) != 16'sh0000 || !STEP_OUT))
        else $error("step pulse too long");

    a_seed_velocity: assert property (
        handover_go |=> HANDOVER && RAMP_SEED.vel == ($past(DIR_OUT) ? $past(start_velocity_q) : -$past(start_velocity_q)))
        else $error("seed velocity wrong");

    a_seed_accel: assert property (
        handover_go |=> RAMP_SEED.acc[31] == ($past(start_acceleration_q[31]) && $past(start_acceleration_q[30:0]) != 31'h0))
        else $error("seed acceleration sign wrong");

    a_seed_phase: assert property (
        handover_go |=> RAMP_SEED.phase == $past(phase_q) && RAMP_EN)
        else $error("seed phase wrong");

    c_handover: cover property (handover_go ##1 HANDOVER);
    c_indirect_move: cover property (acc_v && state_q == ST_INDIRECT);
    c_burst: cover property (acc_v && acc_cnt > 8'h01 && state_q == ST_DIRECT);
    c_toggle: cover property (cfg_q.step_mode == MODE_TOGGLE && ext_q);

endmodule : esg_top

// *** test/esg_step_src.sv ***
`timescale 1ns/1ps
module esg_step_src (
    // clock
    input  wire logic clk,
    // step and direction pins
    output logic      step,
    output logic      dir
);
    initial begin
        step = 1'b0;
        dir  = 1'b0;
    end

    // ------------------------------------------------------------
    // toggle the step line n times, gap cycles apart
    // ------------------------------------------------------------
    task automatic run(input int n, input int gap, input logic d);
        @(posedge clk);
        dir <= d;
        repeat (gap) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            step <= ~step;
            repeat (gap) @(posedge clk);
        end
    endtask : run
endmodule : esg_step_src

// *** test/tb_esg_top.sv ***
`timescale 1ns/1ps
module tb_esg_top;
    import esg_pkg::*;
    logic        CLK_SYS = 1'b0;
    logic        SRST    = 1'b1;
    logic [7:0]  ADDR    = 8'h00;
    logic [31:0] WDATA   = 32'h0;
    logic        WR      = 1'b0;
    logic        RD      = 1'b0;
    logic [31:0] RDATA;
    logic        STEP_IN, DIR_IN, STEP_OUT, DIR_OUT, INT_GEN_EN, RAMP_EN, HANDOVER;
    logic [9:0]  SINE_POS;
    logic [31:0] TARGET_POS, a0, t0, mag;
    esg_seed_t   seed;
    int          fails = 0, n_tests = 0, pcnt = 0, b, e, c;
    int          cyc = 0, lastp = 0;
    logic [9:0]  s_exp = 10'h0;
    logic        pdir;
    logic [1:0]  t_md [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h3, 2'h3, 2'h1};
    logic [31:0] t_gr [8] = '{32'h0100_0000, 32'h0100_0000, 32'h0100_0000, 32'h0080_0000,
                              32'h0200_0000, 32'hFF00_0000, 32'h0000_0001, 32'h7F00_0000};
    logic        t_dr [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic        t_pl [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    int          t_n  [8] = '{4, 4, 4, 4, 4, 4, 4, 1};

    esg_top dut (.CLK_SYS(CLK_SYS), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .STEP_IN(STEP_IN), .DIR_IN(DIR_IN), .STEP_OUT(STEP_OUT), .DIR_OUT(DIR_OUT),
        .SINE_POS(SINE_POS), .INT_GEN_EN(INT_GEN_EN), .RAMP_EN(RAMP_EN), .TARGET_POS(TARGET_POS),
        .HANDOVER(HANDOVER), .RAMP_SEED(seed));
    esg_step_src src (.clk(CLK_SYS), .step(STEP_IN), .dir(DIR_IN));

    always #4 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        if (STEP_OUT === 1'b1) begin
            pcnt  <= pcnt + 1;
            lastp <= cyc;
        end
    end

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        ADDR <= a; WDATA <= d; WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK_SYS);
        ADDR <= a; RD <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        logic [31:0] d;
        rd(a, d);
        chk(nm, ex, d);
    endtask : rchk
    function automatic logic [31:0] cfg(input logic [1:0] m, input logic p, s, au);
        return (32'(au) << AUTO_BIT) | (32'(s) << STEER_BIT) | (32'(p) << POL_BIT) | (32'(m) << MODE_LSB);
    endfunction : cfg
    task automatic summarize();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    initial begin
        repeat (30000) @(posedge CLK_SYS);
        fails++;
        summarize();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge CLK_SYS);
        SRST <= 1'b0;
        rchk("global", 8'h00, 32'h0);
        rchk("gear", 8'h48, GEAR_RST);
        rchk("start_velocity", 8'h94, 32'h0);
        rchk("start_acceleration", 8'hA8, 32'h0);
        rchk("target", 8'hDC, 32'h0);
        wr(8'h04, 32'hA5A5_A5A5);
        rchk("unmapped", 8'h04, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(8'h48, t_gr[i]);
            wr(8'h00, cfg(t_md[i], t_pl[i], 1'b0, 1'b0));
            e = (t_md[i] == 2'h0) ? 0 : (t_md[i] == 2'h3) ? t_n[i] : (t_md[i] == 2'h1) ? (t_n[i] + 1) / 2 : t_n[i] / 2;
            mag = t_gr[i][31] ? -t_gr[i] : t_gr[i];
            c = int'((64'(e) * 64'(mag)) >> 24);
            pdir = t_dr[i] ^ t_pl[i] ^ t_gr[i][31];
            s_exp = pdir ? s_exp + 10'(c) : s_exp - 10'(c);
            b = pcnt;
            src.run(t_n[i], 8, t_dr[i]);
            repeat (2 * c + 20) @(posedge CLK_SYS);
            chk("steps", 32'(c), 32'(pcnt - b));
            chk("gen_en", 32'(t_md[i] == 2'h0), 32'(INT_GEN_EN));
            if (c > 0) chk("dir", 32'(pdir), 32'(DIR_OUT));
            chk("sine", 32'(s_exp), 32'(SINE_POS));
        end
        wr(8'h48, 32'h0100_0000);
        wr(8'h00, cfg(2'h3, 1'b0, 1'b1, 1'b0));
        rd(8'h84, a0);
        rd(8'hDC, t0);
        src.run(4, 70, 1'b1);
        repeat (20) @(posedge CLK_SYS);
        rchk("target_up", 8'hDC, t0 + 32'h4);
        rchk("actual", 8'h84, a0);
        chk("target_pos", t0 + 32'h4, TARGET_POS);
        chk("ramp_en", 32'h1, 32'(RAMP_EN));
        src.run(4, 70, 1'b0);
        repeat (20) @(posedge CLK_SYS);
        rchk("target_dn", 8'hDC, t0);
        wr(8'h00, cfg(2'h1, 1'b0, 1'b0, 1'b1));
        wr(8'h94, 32'h0000_1234);
        wr(8'hA8, 32'h8000_0010);
        src.run(2, 8, 1'b1);
        repeat (20) @(posedge CLK_SYS);
        chk("direct_ramp", 32'h0, 32'(RAMP_EN));
        wr(8'h00, cfg(2'h0, 1'b0, 1'b0, 1'b1));
        for (int k = 0; k < 10 && HANDOVER !== 1'b1; k++) @(posedge CLK_SYS) #1;
        chk("handover", 32'h1, 32'(HANDOVER));
        chk("seed_vel", 32'h0000_1234, seed.vel);
        chk("seed_acc", 32'hFFFF_FFF0, seed.acc);
        chk("seed_phase", 32'(cyc - 2 - lastp), 32'(seed.phase));
        chk("ramp_on", 32'h1, 32'(RAMP_EN));
        rchk("auto_clr", 8'h00, 32'h0);
        rchk("status", 8'h3C, 32'h0000_0037);
        summarize();
    end
endmodule : tb_esg_top
